/* bench/adc_format_timing_flags_properties.sv */
// port checker for the format, timing and flag block
// assumes it is bound to the block top; one clock domain
`include "adc_ctrl_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module adc_format_timing_flags_chk
	import adc_ctrl_pkg::*;
(
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire cmd_result_s result,
	input wire logic        result_valid,
	input wire logic        converter_running,
	input wire logic        conv_clk,
	input wire logic        irq
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rstn);
	// zero-wait slave: access cycle always answered
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready in access cycle");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("ready outside access cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	// divided clock parks low once stopped
	a_clk_parks_idle: assert property (!converter_running [*2] |-> !conv_clk)
		else $error("conversion clock runs while idle");
	a_result_after_done: assert property (result.done && converter_running |=> result_valid)
		else $error("stored result not reported");
	a_valid_has_cause: assert property (result_valid |-> $past(result.done))
		else $error("result without done");
	a_list_end_idles: assert property (result.done && converter_running
		&& result.cmd_type == `CMD_TYPE_EOL |=> !converter_running)
		else $error("list end kept running");
	// a control write in flight could legally stop the run, so exclude it
	a_mid_list_runs: assert property (result.done && converter_running
		&& result.cmd_type != `CMD_TYPE_EOL && !(psel && pwrite) |=> converter_running)
		else $error("run stopped mid list");
	c_result: cover property (result_valid);
	c_irq: cover property (irq);
	c_clk: cover property ($rose(conv_clk));
endmodule
bind adc_format_timing_flags adc_format_timing_flags_chk u_chk (.clk(clk), .rstn(rstn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
	.result(result), .result_valid(result_valid), .converter_running(converter_running),
	.conv_clk(conv_clk), .irq(irq));
`default_nettype wire

/* bench/adc_format_timing_flags_tb.sv */
// self-checking bench for the format, timing and flag block
// assumes the zero-wait apb slave and sequencer contract of the block
`include "adc_ctrl_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module adc_format_timing_flags_tb
	import adc_ctrl_pkg::*;
;
	logic        clk, rstn, psel, penable, pwrite, pready, pslverr, err;
	logic        conv_start, result_valid, converter_running, conv_clk, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] result_word;
	cmd_result_s result;
	chan_dec_s   channel;
	int          mismatches, cmp_count, p;
	// format settings and the word each gives for sample ABC
	logic [7:0]  fmt [6] = '{8'h00, 8'h80, 8'h02, 8'h82, 8'h04, 8'h84};
	logic [15:0] fw [6] = '{16'hAB00, 16'h00AB, 16'hABC0, 16'h02AF, 16'hABC0, 16'h0ABC};
	logic [5:0]  cc [9] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h08, 6'h0F, 6'h10, 6'h1F, 6'h20};
	chan_kind_e  ck [9] = '{CH_REF_LOW, CH_REF_HIGH, CH_REF_MID, CH_RESERVED, CH_INTERNAL,
		CH_INTERNAL, CH_EXTERNAL, CH_EXTERNAL, CH_RESERVED};
	// expected source number where the code picks a numbered source
	logic [3:0]  ci [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h0, 4'h7, 4'h0, 4'hF, 4'h0};

	adc_format_timing_flags u_adc_format_timing_flags (.clk(clk), .rstn(rstn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .conv_start(conv_start), .result(result),
		.result_word(result_word), .result_valid(result_valid),
		.converter_running(converter_running), .conv_clk(conv_clk), .channel(channel), .irq(irq));

	// 50 ns bus clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			report_and_stop();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	// one stored result: done pulse, then report seen the cycle after
	task automatic seq(input logic [3:0] fs, input logic [1:0] ty, input logic [15:0] w);
		@(posedge clk);
		result <= '{1'b1, fs, ty, 12'hABC};
		@(posedge clk);
		result.done <= 1'b0;
		@(posedge clk);
		chk({31'h0, result_valid}, 32'h1);
		chk({16'h0, result_word}, {16'h0, w});
	endtask

	task automatic start();
		@(posedge clk);
		conv_start <= 1'b1;
		@(posedge clk);
		conv_start <= 1'b0;
	endtask

	// edges between two rising samples of the divided clock, bounded
	task automatic period(output int q);
		int n;
		n = 0;
		q = 0;
		for (int k = 0; k < 4; k++) begin
			while (conv_clk !== k[0] && n < 100) begin
				@(posedge clk);
				n++;
				q += (k > 1);
			end
		end
		if (n >= 100) begin
			mismatches++;
			report_and_stop();
		end
	endtask

	initial begin
		{rstn, psel, penable, pwrite, conv_start} = '0;
		paddr = '0;
		pwdata = '0;
		result = '0;
		mismatches = 0;
		cmp_count = 0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		rdc(`ADDR_DIVIDER, 32'h0);
		rdc(`ADDR_FLAGS, 32'h0);
		apb(1'b0, 12'h030, 32'h0);
		chk({31'h0, err}, 32'h1);
		// settings accepted while disabled, dropped once enabled
		wr(`ADDR_DIVIDER, 32'h3);
		wr(`ADDR_FORMAT, 32'h84);
		wr(`ADDR_CONTROL, 32'h1);
		wr(`ADDR_DIVIDER, 32'h5);
		rdc(`ADDR_DIVIDER, 32'h3);
		wr(`ADDR_FORMAT, 32'h0);
		rdc(`ADDR_FORMAT, 32'h84);
		start();
		period(p);
		chk(p, 8);
		$display("test gating and divider finished");
		// special access reopens the format while running
		wr(`ADDR_CONTROL, 32'h3);
		for (int i = 0; i < 6; i++) begin
			wr(`ADDR_FORMAT, {24'h0, fmt[i]});
			rdc(`ADDR_FORMAT, {24'h0, fmt[i]});
			seq(4'(i + 1), 2'h0, fw[i]);
		end
		wr(`ADDR_CONTROL, 32'h1);
		rdc(`ADDR_FLAGS, 32'h7E);
		seq(4'h1, 2'h0, 16'h0ABC);
		rdc(`ADDR_CONTROL, 32'h601);
		wr(`ADDR_FLAGS, 32'h3);
		rdc(`ADDR_FLAGS, 32'h7C);
		wr(`ADDR_FLAGS, 32'h0);
		rdc(`ADDR_FLAGS, 32'h7C);
		seq(4'h0, `CMD_TYPE_EOL, 16'h0ABC);
		rdc(`ADDR_FLAGS, 32'h7D);
		chk({31'h0, converter_running}, 32'h0);
		$display("test formats and flags finished");
		wr(`ADDR_IRQ_ENABLE, 32'h1);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		wr(`ADDR_IRQ_ENABLE, 32'h0);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		wr(`ADDR_IRQ_ENABLE, 32'h1);
		wr(`ADDR_IRQ_CLEAR, 32'h1);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rdc(`ADDR_IRQ_STATUS, 32'h6);
		$display("test interrupt finished");
		wr(`ADDR_CONTROL, 32'h5);
		rdc(`ADDR_FLAGS, 32'h0);
		rdc(`ADDR_CONTROL, 32'h5);
		wr(`ADDR_CONTROL, 32'h0);
		wr(`ADDR_FORMAT, 32'h1);
		wr(`ADDR_CONTROL, 32'h1);
		start();
		rdc(`ADDR_CONTROL, 32'h901);
		chk({31'h0, converter_running}, 32'h0);
		rdc(`ADDR_IRQ_STATUS, 32'hE);
		$display("test reset and reserved finished");
		for (int i = 0; i < 9; i++) begin
			wr(`ADDR_CHANNEL, {26'h0, cc[i]});
			repeat (2) @(posedge clk);
			chk({29'h0, channel.kind}, {29'h0, ck[i]});
			if (cc[i][5:3] != 3'h0 && !cc[i][5]) begin
				chk(32'(channel.index), 32'(ci[i]));
			end
		end
		$display("test channel finished");
		report_and_stop();
	end
endmodule
`default_nettype wire

/* rtl/adc_ctrl_defines.svh */
// constants of the converter format, timing and flag control block
// assumes a 32-bit apb slave with byte addresses and one word per register
// Function
// - conversion clock is bus clock over 2(divide+1)
// - divider writable only when disabled or special access
// - justify and resolution writable under same gating
// - unsigned results, left or right justified
// - resolution codes 000/010/100 give 8/10/12 bits
// - start with reserved resolution: error flag, halt
// - flags clear on write one, never set
// - flags cleared while disabled or soft reset
// - flag select field sets chosen done flag
// - end-of-list command sets bit zero flag
// - setting an already set flag raises overrun
// - channel codes 0/1/2 are references, 3-7 reserved
// - codes 8-15 internal sources, top bit reserved
// - codes 01xxxx select external analog inputs
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

// register byte addresses
`define ADDR_DIVIDER      12'h000
`define ADDR_FORMAT       12'h004
`define ADDR_FLAGS        12'h00C
`define ADDR_CONTROL      12'h010
`define ADDR_CHANNEL      12'h014
`define ADDR_IRQ_STATUS   12'h018
`define ADDR_IRQ_CLEAR    12'h01C
`define ADDR_IRQ_ENABLE   12'h020

// field positions
`define FMT_JUSTIFY_BIT   7
`define CTRL_ENABLE_BIT   0
`define CTRL_SPECIAL_BIT  1
`define CTRL_SRST_BIT     2
`define CTRL_ERR_BIT      8
`define CTRL_OVR_BIT      9
`define CTRL_RUN_BIT      10
`define CTRL_HALT_BIT     11
`define FMT_RES_MSB       2
`define CHAN_MSB          5
`define IRQ_MSB           3
`define FLAG_MSB          15
`define FLAG_EOL_BIT      0
`define FLAG_SEL_NONE     4'h0

// resolution encodings
`define RES_8BIT          3'h0
`define RES_10BIT         3'h2
`define RES_12BIT         3'h4

// command type marking the end of a list
`define CMD_TYPE_EOL      2'h1

// interrupt status bits
`define IRQ_EOL_BIT       0
`define IRQ_DONE_BIT      1
`define IRQ_OVR_BIT       2
`define IRQ_ERR_BIT       3

// reset values
`define RST_DIVIDER       7'h00
`define RST_RES           3'h0
`define RST_FLAGS         16'h0000

`endif

/* rtl/adc_ctrl_pkg.sv */
// types shared by the converter control block and its helpers
// assumes the constants header is included where numbers are needed
package adc_ctrl_pkg;

	// converter sequencing state
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN,
		ST_HALTED
	} conv_state_e;

	// what an analog channel code points at
	typedef enum logic [2:0] {
		CH_REF_LOW,
		CH_REF_HIGH,
		CH_REF_MID,
		CH_INTERNAL,
		CH_EXTERNAL,
		CH_RESERVED
	} chan_kind_e;

	// a finished command handed in by the sequencer
	typedef struct packed {
		logic        done;
		logic [3:0]  flag_sel;
		logic [1:0]  cmd_type;
		logic [11:0] raw;
	} cmd_result_s;

	// decoded channel
	typedef struct packed {
		chan_kind_e kind;
		logic [3:0] index;
	} chan_dec_s;

endpackage

/* rtl/adc_format_timing_flags.sv */
// converter format, timing and flag control with an apb register slave
// assumes the command sequencer runs on clk and pulses result.done once
// per stored result; apb master follows the usual setup/access phases
// and that the divider and channel decoder share its clock and reset
`include "adc_ctrl_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module adc_format_timing_flags
	import adc_ctrl_pkg::*;
#(
	parameter int DIV_W   = 7,
	parameter int NUM_EXT = 16
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	// apb slave
	input  wire logic [11:0]  paddr,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	// sequencer side
	input  wire logic         conv_start,
	input  wire cmd_result_s  result,
	output logic [15:0]       result_word,
	output logic              result_valid,
	output logic              converter_running,
	output logic              conv_clk,
	output chan_dec_s         channel,
	output logic              irq
);

	// all state of the block outside the divider and channel decoder; one struct so every flop here resets and updates
	// in one place, at the cost of a wide register that synthesis splits up
	typedef struct packed {
		logic [DIV_W-1:0] divide;     // clock_divide_value
		logic             justify;    // result_justify_right
		logic [2:0]       res;        // result_resolution_select
		logic             enable;     // converter enable
		logic             special;    // special_mode_write_access
		logic             srst;       // converter_soft_reset
		logic [5:0]       chan;       // input_channel_select
		logic [15:0]      flags;      // list_end_flag and per_command_done_flags
		logic             overrun;    // done_flag_overrun
		logic             cmd_err;    // command_error_flag
		conv_state_e      st;         // sequencing state
		logic [3:0]       irq_stat;   // sticky interrupt status
		logic [3:0]       irq_en;     // interrupt enables
		logic             irq;        // registered interrupt line
		logic [31:0]      prdata;     // read data
		logic             pready;     // access phase answer
		logic             pslverr;    // unmapped address answer
		logic [15:0]      result;     // formatted result
		logic             rvalid;     // result strobe
		logic             running;    // list in progress, drives the pin
	} regs_s;

	// q holds the flops, d the value they take at the next edge
	regs_s q, d;

	// a setting is open to writes while disabled or in special access;
	// the gate looks at the stored control bits, so a control write only
	// opens or closes it for the transfers that follow
	function automatic logic unlocked(input regs_s s);
		return !s.enable || s.special;
	endfunction

	// resolution code is one of the three legal ones; every other code,
	// including every odd code and the codes 110 and 111, is reserved
	function automatic logic res_legal(input logic [2:0] r);
		return (r == `RES_8BIT) || (r == `RES_10BIT) || (r == `RES_12BIT);
	endfunction

	// address hits a mapped register; anything else answers with an error
	// and leaves the state alone
	function automatic logic mapped(input logic [11:0] a);
		logic hit;
		hit = 1'b0;
		if (a == `ADDR_DIVIDER) begin
			hit = 1'b1;
		end else if (a == `ADDR_FORMAT) begin
			hit = 1'b1;
		end else if (a == `ADDR_FLAGS) begin
			hit = 1'b1;
		end else if (a == `ADDR_CONTROL) begin
			hit = 1'b1;
		end else if (a == `ADDR_CHANNEL) begin
			hit = 1'b1;
		end else if (a == `ADDR_IRQ_STATUS) begin
			hit = 1'b1;
		end else if (a == `ADDR_IRQ_CLEAR) begin
			hit = 1'b1;
		end else if (a == `ADDR_IRQ_ENABLE) begin
			hit = 1'b1;
		end
		return hit;
	endfunction

	// read word for an address; write-only clear register reads zero
	// unused bits of every register read zero
	function automatic logic [31:0] read_word(input regs_s s, input logic [11:0] a);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (a == `ADDR_DIVIDER) begin
			// divider reads back the stored value even while locked
			w[DIV_W-1:0] = s.divide;
		end else if (a == `ADDR_FORMAT) begin
			w[`FMT_JUSTIFY_BIT]   = s.justify;
			w[`FMT_RES_MSB:0]     = s.res;
		end else if (a == `ADDR_FLAGS) begin
			w[`FLAG_MSB:0] = s.flags;
		end else if (a == `ADDR_CONTROL) begin
			// low bits are writable, the upper status bits are read-only
			w[`CTRL_ENABLE_BIT]  = s.enable;
			w[`CTRL_SPECIAL_BIT] = s.special;
			w[`CTRL_SRST_BIT]    = s.srst;
			w[`CTRL_ERR_BIT]     = s.cmd_err;
			w[`CTRL_OVR_BIT]     = s.overrun;
			w[`CTRL_RUN_BIT]     = (s.st == ST_RUN);
			w[`CTRL_HALT_BIT]    = (s.st == ST_HALTED);
		end else if (a == `ADDR_CHANNEL) begin
			w[`CHAN_MSB:0] = s.chan;
		end else if (a == `ADDR_IRQ_STATUS) begin
			w[`IRQ_MSB:0] = s.irq_stat;
		end else if (a == `ADDR_IRQ_ENABLE) begin
			w[`IRQ_MSB:0] = s.irq_en;
		end
		return w;
	endfunction

	// unsigned result placement; raw sample is msb aligned at 12 bits
	// right justified: the kept bits sit at the bottom of the word
	// left justified: the kept bits sit at the top, low bits read zero
	// a reserved resolution written under special access mid-list takes the twelve-bit branch
	function automatic logic [15:0] format_result(input logic [11:0] raw,
		input logic [2:0] res, input logic rj);
		logic [11:0] v;
		logic [15:0] w;
		v = raw;
		w = 16'h0000;
		if (res == `RES_8BIT) begin
			v = {raw[11:4], 4'h0};
			w = {8'h00, raw[11:4]};
		end else if (res == `RES_10BIT) begin
			v = {raw[11:2], 2'h0};
			w = {6'h00, raw[11:2]};
		end else begin
			// twelve bits keep the full sample
			w = {4'h0, raw};
		end
		if (!rj) begin
			w = {v, 4'h0};
		end
		return w;
	endfunction

	// per-cycle helpers, all but presc_run given a value at the top of the process
	logic             wr_access;  // write taken at this edge
	logic             setup;      // setup phase of any transfer
	logic [15:0]      set_mask;   // flags being set this cycle
	logic [15:0]      clr_mask;   // flags being cleared by software
	logic [3:0]       irq_set;    // events for the interrupt status
	logic             flag_wipe;  // disable or soft reset clears flags
	logic             presc_run;  // conversion clock allowed to run

	// next state of the registers and the sequencing
	always_comb begin
		// start from the held state; every branch below only overrides
		d          = q;
		setup      = psel && !penable;
		// a write lands at the edge that ends its access cycle
		wr_access  = psel && penable && q.pready && pwrite && !q.pslverr;
		set_mask   = 16'h0000;
		clr_mask   = 16'h0000;
		irq_set    = 4'h0;
		flag_wipe  = !q.enable || q.srst;
		// the result strobe is a single cycle unless renewed below
		d.rvalid   = 1'b0;

		// zero wait state answer: prepared in setup, given in access;
		// read data is captured in setup so it stands still for the whole
		// access cycle even if a result or flag changes meanwhile
		d.pready  = setup;
		d.pslverr = setup && !mapped(paddr);
		if (setup && !pwrite) begin
			d.prdata = read_word(q, paddr);
		end else if (setup) begin
			d.prdata = 32'h0000_0000;
		end

		// register writes; gated settings drop a locked write silently
		// an unmapped write is dropped because pslverr blocks wr_access
		if (wr_access) begin
			if (paddr == `ADDR_DIVIDER) begin
				if (unlocked(q)) begin
					d.divide = pwdata[DIV_W-1:0];
				end
			end else if (paddr == `ADDR_FORMAT) begin
				if (unlocked(q)) begin
					d.justify = pwdata[`FMT_JUSTIFY_BIT];
					d.res     = pwdata[`FMT_RES_MSB:0];
				end
			end else if (paddr == `ADDR_FLAGS) begin
				clr_mask = pwdata[`FLAG_MSB:0];
			end else if (paddr == `ADDR_CONTROL) begin
				// soft reset is a level: it holds the flags clear until
				// software lowers it again; status bits ignore writes
				d.enable  = pwdata[`CTRL_ENABLE_BIT];
				d.special = pwdata[`CTRL_SPECIAL_BIT];
				d.srst    = pwdata[`CTRL_SRST_BIT];
			end else if (paddr == `ADDR_CHANNEL) begin
				d.chan = pwdata[`CHAN_MSB:0];
			end else if (paddr == `ADDR_IRQ_CLEAR) begin
				// write-only: a one clears that status bit, a zero leaves it
				d.irq_stat = q.irq_stat & ~pwdata[`IRQ_MSB:0];
			end else if (paddr == `ADDR_IRQ_ENABLE) begin
				d.irq_en = pwdata[`IRQ_MSB:0];
			end
		end

		// sequencing; a start is taken only when idle, and a done strobe is
		// only looked at while a list runs, so stray strobes are harmless
		case (q.st)
			ST_IDLE: begin
				// soft reset held high also blocks a start
				if (conv_start && q.enable && !q.srst) begin
					if (res_legal(q.res)) begin
						d.st = ST_RUN;
					end else begin
						// reserved resolution: refuse the start, park until cleared
						d.cmd_err = 1'b1;
						d.st      = ST_HALTED;
						irq_set[`IRQ_ERR_BIT] = 1'b1;
					end
				end
			end
			ST_RUN: begin
				// a stored result is reported one cycle after its done strobe
				if (result.done) begin
					d.result = format_result(result.raw, q.res, q.justify);
					d.rvalid = 1'b1;
					// flag select zero asks for no per-command flag
					if (result.flag_sel != `FLAG_SEL_NONE) begin
						set_mask[result.flag_sel] = 1'b1;
						irq_set[`IRQ_DONE_BIT]   = 1'b1;
					end
					if (result.cmd_type == `CMD_TYPE_EOL) begin
						set_mask[`FLAG_EOL_BIT] = 1'b1;
						irq_set[`IRQ_EOL_BIT] = 1'b1;
						d.st = ST_IDLE;
					end
				end
			end
			ST_HALTED: begin
				// all operation stopped until disabled or soft reset
				// only the wipe below can leave this state
				d.st = ST_HALTED;
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase

		// a flag set again while still set is an overrun
		// overrun stays set until disable or soft reset, like the error flag
		if ((set_mask & q.flags) != 16'h0000) begin
			d.overrun = 1'b1;
			irq_set[`IRQ_OVR_BIT] = 1'b1;
		end

		// set wins over a software clear in the same cycle
		// so a result landing during a clear is never lost
		d.flags = (q.flags & ~clr_mask) | set_mask;

		// disable and soft reset clear the flags, overrun and error flag
		// placed last so a wipe beats a set arriving in the same cycle
		// disable also aborts a running list and releases a halt
		if (flag_wipe) begin
			d.flags   = `RST_FLAGS;
			d.overrun = 1'b0;
			d.cmd_err = 1'b0;
			d.st      = ST_IDLE;
		end

		// sticky interrupt status, set wins over clear
		// a wipe leaves the status alone; only software clears it
		d.irq_stat = d.irq_stat | irq_set;
		d.irq      = |(d.irq_stat & d.irq_en);

		// running flag kept in a flop so the pin has no decode behind it
		d.running  = (d.st == ST_RUN);
	end

	// register the whole state
	// reset values come from the constants header so bench and logic agree
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q        <= '0;
			q.divide <= `RST_DIVIDER;
			q.res    <= `RST_RES;
			q.flags  <= `RST_FLAGS;
			q.st     <= ST_IDLE;
		end else begin
			q <= d;
		end
	end

	// divider only runs while a list is being converted; stopping it
	// parks the divided clock low so the next list starts from a known phase
	assign presc_run = q.running;

	// conversion clock
	// divide may change mid-list under special access; lowering it below
	// the running count stretches one half period
	conv_clock_prescaler #(
		.DIV_W (DIV_W)
	) u_presc (
		.clk      (clk),
		.rstn     (rstn),
		.run      (presc_run),
		.divide   (q.divide),
		.conv_clk (conv_clk)
	);

	// channel select decode
	// decode is registered, so channel follows the register one cycle late
	// external inputs beyond NUM_EXT decode as reserved
	channel_decoder #(
		.NUM_EXT (NUM_EXT)
	) u_chan (
		.clk  (clk),
		.rstn (rstn),
		.code (q.chan),
		.dec  (channel)
	);

	// outputs straight from the state flops
	// every pin below is a flop of the state struct or of a helper
	assign prdata            = q.prdata;
	assign pready            = q.pready;
	assign pslverr           = q.pslverr;
	assign result_word       = q.result;
	assign result_valid      = q.rvalid;
	assign converter_running = q.running;
	assign irq               = q.irq;

endmodule
`default_nettype wire

/* rtl/channel_decoder.sv */
// analog input channel select decoder, registered result
// assumes the channel code comes from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module channel_decoder
	import adc_ctrl_pkg::*;
#(
	parameter int NUM_EXT = 16
) (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic [5:0] code,
	output chan_dec_s       dec
);

	chan_dec_s q, d;

	// decode by the upper bits first
	always_comb begin
		d.kind  = CH_RESERVED;
		d.index = code[3:0];
		if (code[5]) begin
			d.kind = CH_RESERVED;
		end else if (code[4]) begin
			// external inputs beyond those fitted are reserved
			if (32'(code[3:0]) < NUM_EXT) begin
				d.kind = CH_EXTERNAL;
			end
		end else if (code[3]) begin
			d.kind  = CH_INTERNAL;
			d.index = {1'b0, code[2:0]};
		end else if (code[2:0] == 3'h0) begin
			d.kind = CH_REF_LOW;
		end else if (code[2:0] == 3'h1) begin
			d.kind = CH_REF_HIGH;
		end else if (code[2:0] == 3'h2) begin
			d.kind = CH_REF_MID;
		end
	end

	// register the decode
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q <= '{kind: CH_REF_LOW, index: 4'h0};
		end else begin
			q <= d;
		end
	end

	assign dec = q;

endmodule
`default_nettype wire

/* rtl/conv_clock_prescaler.sv */
// conversion clock divider: bus clock over 2*(divide+1)
// assumes divide is stable while run is high
`timescale 1ns/10ps
`default_nettype none
module conv_clock_prescaler
	import adc_ctrl_pkg::*;
#(
	parameter int DIV_W = 7
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             run,
	input  wire logic [DIV_W-1:0] divide,
	output logic                  conv_clk
);

	// all state of the divider
	typedef struct packed {
		logic [DIV_W-1:0] count;  // cycles in the current half period
		logic             level;  // divided clock level
	} presc_s;

	presc_s q, d;

	// toggle every divide+1 cycles, giving a full period of 2*(divide+1)
	always_comb begin
		d = q;
		if (!run) begin
			d.count = '0;
			d.level = 1'b0;
		end else if (q.count == divide) begin
			d.count = '0;
			d.level = ~q.level;
		end else begin
			d.count = q.count + 1'b1;
		end
	end

	// register the state
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign conv_clk = q.level;

endmodule
`default_nettype wire
